// *** logic/baseband_irq_and_phy_control.sv ***
// Purpose: Baseband receive/transmit events, status/mask and PHY control register
// Assumes: Byte register port with one-cycle write/read strobes from the serial control port
// Notes:   Receive-side event inputs are one-cycle pulses from the PHY
//
// Behaviour
// - With address filter on, extended frame raises event after header parse.
// - With address filter on, matching frame raises event after header parse.
// - Transmit-end event rises when the last frame part is sent.
// - Preamble of selected PHY raises gain-hold and freezes gain.
// - Gain-hold and gain-release clear each other; status shows the last.
// - Receive end or cancel raises gain-release; gain control resumes adapting.
// - Gain-release during reception abandons it and restarts receiving.
// - Buffer-level event when received octets reach programmed low/high threshold.
// - After cancel, further receive events are suppressed; restart pulses in the same cycle as gain-release.
// - Reception cancels on signal discontinuity or missing valid PHY header.
// - Control bit 7 enables continuous transmit; resets to 0.
// - Bit 6 set: frame-end event only for valid checksum; resets 1.
// - Status bit 5 cleared at frame start, set to checksum validity at end.
// - Bit 4 set: checksum overwrites last 2 or 4 payload octets.
// - Bit 3 selects checksum: 0 is 32-bit, 1 is 16-bit; resets 0.
// - Bit 2 switches baseband on when 1; resets to 1.
// - Core has own event status and mask registers enabling each event.
// - Bits 1:0 phy kind: off, FSK, OFDM, O-QPSK; resets 0.
// - Core disabled when enable bit or phy kind is 0.
`timescale 1ns/10ps
`include "bb_irq_consts.svh"

module baseband_irq_and_phy_control
    import bb_irq_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        addr_filter_on,
    input  wire logic        rx_frame_start,
    input  wire logic        rx_header_parsed,
    input  wire logic        rx_is_extended,
    input  wire logic        rx_is_match,
    input  wire logic        rx_preamble_seen,
    input  wire logic        rx_signal_break,
    input  wire logic        rx_header_invalid,
    input  wire logic        rx_octet_stored,
    input  wire logic        rx_frame_done,
    input  wire logic        rx_checksum_good,
    input  wire logic        tx_last_sent,
    input  wire logic [10:0] tx_frame_len,
    input  wire logic [10:0] tx_octet_idx,
    output logic             baseband_enabled,
    output logic             continuous_tx,
    output logic             checksum_type,
    output logic             tx_insert_checksum,
    output logic             gain_freeze,
    output logic             rx_restart,
    output logic             irq
);

    // ****************************************
    // Registers
    // ****************************************
    logic      [7:0]  pc_reg;
    logic      [7:0]  status_reg;
    logic      [7:0]  mask_reg;
    logic      [7:0]  level_low_reg;
    logic      [7:0]  level_high_reg;
    logic      [10:0] octet_cnt_reg;
    rx_state_e        rx_state_reg;
    logic      [7:0]  ev_set;
    logic      [7:0]  ev_clr;
    logic      [7:0]  status_next;
    logic             core_on;
    logic             rx_live;
    logic             cancel_now;
    logic      [10:0] level_thr;
    logic      [2:0]  chk_len;
    logic             wr_status;

    assign core_on   = pc_reg[`PC_BB_ON] && (phy_kind_e'(pc_reg[1:0]) != PHY_OFF);
    assign rx_live   = core_on && (rx_state_reg == RX_ACTIVE);
    assign cancel_now = rx_live && (rx_signal_break || rx_header_invalid);
    assign level_thr = {level_high_reg[2:0], level_low_reg};
    assign chk_len   = pc_reg[`PC_CHK_TYPE] ? `CHK16_OCTETS : `CHK32_OCTETS;
    assign wr_status = reg_wr && (reg_addr == `OFS_EVENT_STATUS);

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pc_reg <= `PC_RESET;
        end
        else
        begin
            if (reg_wr && (reg_addr == `OFS_PHY_CONTROL))
            begin
                // Checksum-ok bit is read-only, writes keep it
                pc_reg <= {reg_wdata[7:6], pc_reg[`PC_CHK_OK], reg_wdata[4:0]};
            end
            if (core_on && rx_frame_start)
            begin
                pc_reg[`PC_CHK_OK] <= 1'b0;
            end
            else if (rx_live && rx_frame_done)
            begin
                pc_reg[`PC_CHK_OK] <= rx_checksum_good;
            end
        end
    end

    // ****************************************
    // Threshold and mask registers
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mask_reg       <= `MASK_RESET;
            level_low_reg  <= `LEVEL_RESET;
            level_high_reg <= `LEVEL_RESET;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `OFS_EVENT_MASK: mask_reg       <= reg_wdata;
                `OFS_LEVEL_LOW:  level_low_reg  <= reg_wdata;
                `OFS_LEVEL_HIGH: level_high_reg <= reg_wdata;
                default:         mask_reg       <= mask_reg;
            endcase
        end
    end

    // ****************************************
    // Receive sequencing
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_state_reg <= RX_IDLE;
        end
        else if (!core_on)
        begin
            rx_state_reg <= RX_IDLE;
        end
        else
        begin
            case (rx_state_reg)
                RX_IDLE:
                    if (rx_frame_start)
                        rx_state_reg <= RX_ACTIVE;
                RX_ACTIVE:
                    if (cancel_now)
                        rx_state_reg <= RX_CANCEL;
                    else if (rx_frame_done)
                        rx_state_reg <= RX_IDLE;
                RX_CANCEL:
                    rx_state_reg <= RX_IDLE;
                default:
                    rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // Received octet counter, restarts with each frame
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            octet_cnt_reg <= 11'h000;
        end
        else if (core_on && rx_frame_start)
        begin
            octet_cnt_reg <= 11'h000;
        end
        else if (rx_live && rx_octet_stored)
        begin
            octet_cnt_reg <= octet_cnt_reg + 11'h001;
        end
    end

    // ****************************************
    // Event sources
    // ****************************************
    always_comb
    begin
        ev_set = 8'h00;
        ev_set[`EV_FRAME_START] = core_on && rx_frame_start && (rx_state_reg == RX_IDLE);
        ev_set[`EV_FRAME_END]   = rx_live && !cancel_now && rx_frame_done
                                  && (rx_checksum_good || !pc_reg[`PC_CHK_FILT]);
        ev_set[`EV_EXT_MATCH]   = rx_live && !cancel_now && addr_filter_on
                                  && rx_header_parsed && rx_is_extended;
        ev_set[`EV_ADDR_MATCH]  = rx_live && !cancel_now && addr_filter_on
                                  && rx_header_parsed && rx_is_match;
        ev_set[`EV_TX_END]      = core_on && tx_last_sent;
        ev_set[`EV_GAIN_HOLD]   = rx_live && !cancel_now && !rx_frame_done
                                  && rx_preamble_seen;
        ev_set[`EV_GAIN_REL]    = cancel_now || (rx_live && rx_frame_done);
        ev_set[`EV_BUF_LEVEL]   = rx_live && !cancel_now && rx_octet_stored
                                  && ((octet_cnt_reg + 11'h001) == level_thr);
    end

    // Write one to clear; a same-cycle event wins over the clear
    always_comb
    begin
        ev_clr = wr_status ? reg_wdata : 8'h00;
        ev_clr[`EV_GAIN_HOLD] = ev_clr[`EV_GAIN_HOLD] || ev_set[`EV_GAIN_REL];
        ev_clr[`EV_GAIN_REL]  = ev_clr[`EV_GAIN_REL] || ev_set[`EV_GAIN_HOLD];
        status_next = (status_reg & ~ev_clr) | ev_set;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            status_reg <= 8'h00;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(status_next & mask_reg);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gain_freeze <= 1'b0;
        end
        else if (ev_set[`EV_GAIN_HOLD])
        begin
            gain_freeze <= 1'b1;
        end
        else if (ev_set[`EV_GAIN_REL] || !core_on)
        begin
            gain_freeze <= 1'b0;
        end
    end

    // One-cycle pulse, a cycle after the cancel that caused it
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_restart <= 1'b0;
        end
        else
        begin
            rx_restart <= cancel_now;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            baseband_enabled <= 1'b0;
        end
        else
        begin
            baseband_enabled <= core_on;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            continuous_tx <= 1'b0;
        end
        else
        begin
            // Forced off with the core so a disabled baseband never streams
            continuous_tx <= core_on && pc_reg[`PC_CONT_TX];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            checksum_type <= 1'b0;
        end
        else
        begin
            checksum_type <= pc_reg[`PC_CHK_TYPE];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_insert_checksum <= 1'b0;
        end
        else
        begin
            // Short frames would underflow; the frame length compare holds insertion off for them
            tx_insert_checksum <= core_on && pc_reg[`PC_AUTO_CHK]
                                  && (tx_frame_len > {8'h00, chk_len})
                                  && (tx_octet_idx >= (tx_frame_len - {8'h00, chk_len}));
        end
    end

    // Read data registered one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                `OFS_PHY_CONTROL:  reg_rdata <= pc_reg;
                `OFS_EVENT_STATUS: reg_rdata <= status_reg;
                `OFS_EVENT_MASK:   reg_rdata <= mask_reg;
                `OFS_LEVEL_LOW:    reg_rdata <= level_low_reg;
                `OFS_LEVEL_HIGH:   reg_rdata <= level_high_reg;
                default:           reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule : baseband_irq_and_phy_control

// *** logic/bb_irq_consts.svh ***
// Purpose: Offsets, field positions, reset values for the baseband event block
// Assumes: Byte-wide register port, local addresses
// Notes:   Offsets are local to this block
`ifndef BB_IRQ_CONSTS_SVH
`define BB_IRQ_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_PHY_CONTROL      4'h0
`define OFS_EVENT_STATUS     4'h1
`define OFS_EVENT_MASK       4'h2
`define OFS_LEVEL_LOW        4'h3
`define OFS_LEVEL_HIGH       4'h4

// ****************************************
// Control register fields
// ****************************************
`define PC_CONT_TX           7
`define PC_CHK_FILT          6
`define PC_CHK_OK            5
`define PC_AUTO_CHK          4
`define PC_CHK_TYPE          3
`define PC_BB_ON             2
`define PC_RESET             8'h54

// ****************************************
// Event status bit positions
// ****************************************
`define EV_FRAME_START       0
`define EV_FRAME_END         1
`define EV_EXT_MATCH         2
`define EV_ADDR_MATCH        3
`define EV_TX_END            4
`define EV_GAIN_HOLD         5
`define EV_GAIN_REL          6
`define EV_BUF_LEVEL         7

`define MASK_RESET           8'h00
`define LEVEL_RESET          8'h00
`define CHK16_OCTETS         3'h2
`define CHK32_OCTETS         3'h4

`endif

// *** logic/bb_irq_pkg.sv ***
// Purpose: Types for the baseband event block
// Assumes: Used with bb_irq_consts.svh
// Notes:   Types only
package bb_irq_pkg;

    typedef enum logic [1:0]
    {
        PHY_OFF  = 2'b00,
        PHY_FSK  = 2'b01,
        PHY_OFDM = 2'b10,
        PHY_OQPSK = 2'b11
    } phy_kind_e;

    typedef enum logic [1:0]
    {
        RX_IDLE   = 2'b00,
        RX_ACTIVE = 2'b01,
        RX_CANCEL = 2'b10
    } rx_state_e;

endpackage : bb_irq_pkg

// *** sim/bb_irq_checker.sv ***
// Purpose: Port assertions for the baseband event block
// Assumes: One clock, async active-low reset
// Notes:   Bound to the baseband event module by the bind below
`timescale 1ns/10ps

module bb_irq_checker
(
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        reg_wr,
    input wire logic        rx_preamble_seen,
    input wire logic        rx_signal_break,
    input wire logic        rx_header_invalid,
    input wire logic        rx_frame_done,
    input wire logic [10:0] tx_frame_len,
    input wire logic [10:0] tx_octet_idx,
    input wire logic        baseband_enabled,
    input wire logic        continuous_tx,
    input wire logic        checksum_type,
    input wire logic        tx_insert_checksum,
    input wire logic        gain_freeze,
    input wire logic        rx_restart
);
    // ****************************************
    // Helpers and properties
    // ****************************************
    wire        cut     = rx_signal_break | rx_header_invalid;
    wire [10:0] chk_len = checksum_type ? 11'h002 : 11'h004;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    AST_RESTART_CAUSE: assert property (rx_restart |-> $past(cut))
        else $error("restart without a cancel cause");
    AST_RESTART_PULSE: assert property (rx_restart |=> !rx_restart)
        else $error("restart longer than one cycle");
    AST_FREEZE_REL: assert property (gain_freeze && (rx_frame_done || cut) |-> ##[1:2] !gain_freeze)
        else $error("gain not released at receive end");
    AST_FREEZE_ON: assert property ($rose(gain_freeze) |-> $past(rx_preamble_seen))
        else $error("gain frozen without preamble");
    AST_RESTART_FREE: assert property (rx_restart |-> !gain_freeze)
        else $error("restart while gain frozen");
    AST_DIS_QUIET: assert property (!baseband_enabled |=> !$rose(gain_freeze))
        else $error("disabled core froze gain");
    // Type output and insert flag come from the same control value, so compare them together
    AST_CHK_INSERT: assert property (tx_insert_checksum |-> baseband_enabled
        && ($past(tx_frame_len) > chk_len) && ($past(tx_octet_idx) >= $past(tx_frame_len) - chk_len))
        else $error("checksum inserted out of place");
    AST_CTX_HOLD: assert property (!reg_wr [*2] |=> $stable(continuous_tx))
        else $error("continuous mode changed without write");
    AST_TYPE_HOLD: assert property (!reg_wr [*2] |=> $stable(checksum_type))
        else $error("checksum type changed without write");
endmodule : bb_irq_checker

bind baseband_irq_and_phy_control bb_irq_checker bb_irq_checker_inst
(
    .ref_clk, .rstn, .reg_wr, .rx_preamble_seen, .rx_signal_break, .rx_header_invalid,
    .rx_frame_done, .tx_frame_len, .tx_octet_idx, .baseband_enabled, .continuous_tx,
    .checksum_type, .tx_insert_checksum, .gain_freeze, .rx_restart
);

// *** sim/host_port.sv ***
// Purpose: Host side of the byte register port
// Assumes: Strobes taken at the rising edge
// Notes:   Read data sampled one edge after the read is taken
`timescale 1ns/10ps

module host_port
(
    input  wire logic       ref_clk,
    output logic      [3:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // ****************************************
    // Access tasks
    // ****************************************
    initial
    begin
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask : rd
endmodule : host_port

// *** sim/test_baseband_irq_and_phy_control.sv ***
// Purpose: Self-checking bench for the baseband event block
// Assumes: Host model drives the register port
// Notes:   Receive pulses packed in one vector
`timescale 1ns/10ps
`include "bb_irq_consts.svh"

module test_baseband_irq_and_phy_control;
    logic        ref_clk = 1'b0, rstn = 1'b0;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, rv;
    logic        reg_wr, reg_rd, baseband_enabled, continuous_tx, checksum_type;
    logic        tx_insert_checksum, gain_freeze, rx_restart, irq;
    logic        addr_filter_on = 1'b0, rx_is_extended = 1'b0, rx_is_match = 1'b0, rx_checksum_good = 1'b0;
    logic [7:0]  pl = 8'h00;
    logic [10:0] tx_frame_len = 11'h000, tx_octet_idx = 11'h000;
    logic [7:0]  cz [2] = '{8'h08, 8'h10};
    int          n_mismatch = 0, check_count = 0, i;

    always #2 ref_clk = ~ref_clk;

    host_port host_port_inst (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    baseband_irq_and_phy_control baseband_irq_and_phy_control_inst
    (
        .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .addr_filter_on,
        .rx_frame_start(pl[0]), .rx_header_parsed(pl[1]), .rx_is_extended, .rx_is_match,
        .rx_preamble_seen(pl[2]), .rx_signal_break(pl[3]), .rx_header_invalid(pl[4]),
        .rx_octet_stored(pl[5]), .rx_frame_done(pl[6]), .rx_checksum_good, .tx_last_sent(pl[7]),
        .tx_frame_len, .tx_octet_idx, .baseband_enabled, .continuous_tx, .checksum_type,
        .tx_insert_checksum, .gain_freeze, .rx_restart, .irq
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        host_port_inst.rd(a, rv);
        cmp($sformatf("reg %0h", a), e, rv);
    endtask : rc

    task automatic pulse(input logic [7:0] v);
        @(posedge ref_clk) pl <= v;
        @(posedge ref_clk) pl <= 8'h00;
    endtask : pulse

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : settle

    task automatic give_verdict;
        $display("Mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    // ****************************************
    // Sequence
    // ****************************************
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        rc(`OFS_PHY_CONTROL, `PC_RESET);
        rc(`OFS_EVENT_MASK, `MASK_RESET);
        rc(4'h5, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            host_port_inst.wr(`OFS_PHY_CONTROL, 8'h54 | 8'(i));
            rc(`OFS_PHY_CONTROL, 8'h54 | 8'(i));
            cmp("bb_en", 8'(i != 0), 8'(baseband_enabled));
        end
        host_port_inst.wr(`OFS_PHY_CONTROL, 8'hFF);
        rc(`OFS_PHY_CONTROL, 8'hDF);
        cmp("ctx", 8'h01, 8'(continuous_tx));
        cmp("type", 8'h01, 8'(checksum_type));
        host_port_inst.wr(`OFS_PHY_CONTROL, 8'hFB);
        settle(2);
        cmp("bb_off", 8'h00, 8'(baseband_enabled));
        host_port_inst.wr(`OFS_PHY_CONTROL, 8'h55);
        host_port_inst.wr(`OFS_EVENT_MASK, 8'hFF);
        rc(`OFS_EVENT_MASK, 8'hFF);
        host_port_inst.wr(`OFS_LEVEL_LOW, 8'h02);
        host_port_inst.wr(`OFS_LEVEL_HIGH, 8'h00);
        @(posedge ref_clk);
        {addr_filter_on, rx_is_extended, rx_is_match, rx_checksum_good} <= 4'hF;
        pulse(8'h01);
        pulse(8'h04);
        settle(0);
        cmp("freeze", 8'h01, 8'(gain_freeze));
        pulse(8'h02);
        pulse(8'h20);
        pulse(8'h20);
        pulse(8'h40);
        settle(1);
        cmp("freeze", 8'h00, 8'(gain_freeze));
        rc(`OFS_EVENT_STATUS, 8'hCF);
        rc(`OFS_PHY_CONTROL, 8'h75);
        cmp("irq", 8'h01, 8'(irq));
        host_port_inst.wr(`OFS_EVENT_STATUS, 8'hFF);
        rc(`OFS_EVENT_STATUS, 8'h00);
        cmp("irq", 8'h00, 8'(irq));
        // Length 10 exceeds both checksum lengths, so auto insert is legal
        @(posedge ref_clk) {tx_frame_len, tx_octet_idx} <= {11'h00A, 11'h005};
        settle(2);
        cmp("ins", 8'h00, 8'(tx_insert_checksum));
        @(posedge ref_clk) tx_octet_idx <= 11'h006;
        settle(2);
        cmp("ins", 8'h01, 8'(tx_insert_checksum));
        host_port_inst.wr(`OFS_PHY_CONTROL, 8'h5D);
        settle(2);
        cmp("ins16", 8'h00, 8'(tx_insert_checksum));
        host_port_inst.wr(`OFS_PHY_CONTROL, 8'h55);
        pulse(8'h80);
        rc(`OFS_EVENT_STATUS, 8'h10);
        for (i = 0; i < 2; i++)
        begin
            host_port_inst.wr(`OFS_EVENT_STATUS, 8'hFF);
            pulse(8'h01);
            pulse(8'h04);
            pulse(8'h02);
            pulse(cz[i]);
            for (int w = 0; w < 4 && rx_restart !== 1'b1; w++) @(negedge ref_clk);
            cmp("restart", 8'h01, 8'(rx_restart));
            if (rx_restart !== 1'b1)
                give_verdict();
            pulse(8'h20);
            pulse(8'h20);
            pulse(8'h40);
            // Header parse before the cut still sets extended and match
            rc(`OFS_EVENT_STATUS, 8'h4D);
        end
        host_port_inst.wr(`OFS_EVENT_STATUS, 8'hFF);
        @(posedge ref_clk) rx_checksum_good <= 1'b0;
        pulse(8'h01);
        pulse(8'h40);
        rc(`OFS_EVENT_STATUS, 8'h41);
        rc(`OFS_PHY_CONTROL, 8'h55);
        host_port_inst.wr(`OFS_PHY_CONTROL, 8'h15);
        host_port_inst.wr(`OFS_EVENT_STATUS, 8'hFF);
        @(posedge ref_clk) addr_filter_on <= 1'b0;
        pulse(8'h01);
        pulse(8'h02);
        pulse(8'h40);
        rc(`OFS_EVENT_STATUS, 8'h43);
        host_port_inst.wr(`OFS_EVENT_MASK, 8'h02);
        settle(2);
        cmp("irq", 8'h01, 8'(irq));
        host_port_inst.wr(`OFS_EVENT_MASK, 8'h04);
        settle(2);
        cmp("irq", 8'h00, 8'(irq));
        give_verdict();
    end
endmodule : test_baseband_irq_and_phy_control
